/* design/i2c_cond_detect.sv */
// two-wire receive path, transfer requests and start/stop detection
// Function
// - sync clock pin unused in two-wire mode
// - line levels readable per mode and direction
// - idle clock level follows clock delay option
// - request 14 on ack or eighth fall
// - request 15 on ninth rise or next fall
// - clocked mode stores bits lsb first
// - ack option stores bits msb first
// - split layout: bits to b6..b0, b8
// - first transfer at eighth falling edge
// - second transfer at ninth rising edge
// - start: data falls while clock high
// - stop: data rises while clock high
// - shared request, busy flag tells which
// - nack or ack sampled at ninth rise
// - condition output moves request to completion
module i2c_cond_detect
   import i2c_cond_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // configuration
   input  wire logic [2:0]  serial_mode_select,
   input  wire logic        two_wire_enable,
   input  wire logic        interrupt_option_select,
   input  wire logic        clock_delay_select,
   input  wire logic        clock_polarity_select,
   input  wire logic        condition_output_select,
   input  wire logic        clock_pin_dir_out,
   input  wire logic        data_pin_dir_out,
   input  wire logic        port_data_level,
   input  wire logic        condition_gen_done,
   input  wire logic        condition_clear,
   // pins
   input  wire logic        serial_clock_pin_in,
   output logic             serial_clock_pin_out,
   output logic             serial_clock_pin_oe,
   input  wire logic        serial_data_pin_in,
   output logic             serial_data_pin_out,
   output logic             serial_data_pin_oe,
   input  wire logic        sync_clock_pin_in,
   output logic             sync_clock_pin_out,
   output logic             sync_clock_pin_oe,
   input  wire logic        sync_clock_dir_out,
   // status
   output logic             clock_level,
   output logic             data_level,
   output logic [8:0]       receive_buffer,
   output logic             req_14,
   output logic             req_15,
   output logic             ack_irq,
   output logic             nack_irq,
   output logic             condition_irq,
   output logic             bus_busy_flag
);

   // ----------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------
   logic [1:0] scl_sync_ff, sda_sync_ff, sck_sync_ff;
   logic       scl_prev_ff, sda_prev_ff, sck_prev_ff;
   logic [1:0] nxt_scl_sync, nxt_sda_sync, nxt_sck_sync;
   logic       scl, sda, sck;
   logic       scl_rise, scl_fall, sda_rise, sda_fall, sck_rise, sck_fall;
   logic       two_wire, clocked;

   always_comb begin
      nxt_scl_sync = {scl_sync_ff[0], serial_clock_pin_in};
      nxt_sda_sync = {sda_sync_ff[0], serial_data_pin_in};
      nxt_sck_sync = {sck_sync_ff[0], sync_clock_pin_in};
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         sck_sync_ff <= 2'h3;
         scl_prev_ff <= 1'b1;
         sda_prev_ff <= 1'b1;
         sck_prev_ff <= 1'b1;
      end else begin
         scl_sync_ff <= nxt_scl_sync;
         sda_sync_ff <= nxt_sda_sync;
         sck_sync_ff <= nxt_sck_sync;
         scl_prev_ff <= scl_sync_ff[1];
         sda_prev_ff <= sda_sync_ff[1];
         sck_prev_ff <= sck_sync_ff[1];
      end
   end

   assign scl      = scl_sync_ff[1];
   assign sda      = sda_sync_ff[1];
   assign sck      = sck_sync_ff[1];
   assign scl_rise = scl & ~scl_prev_ff;
   assign scl_fall = ~scl & scl_prev_ff;
   assign sda_rise = sda & ~sda_prev_ff;
   assign sda_fall = ~sda & sda_prev_ff;
   assign sck_rise = sck & ~sck_prev_ff;
   assign sck_fall = ~sck & sck_prev_ff;
   assign two_wire = (serial_mode_select == MODE_TWO_WIRE) & two_wire_enable;
   assign clocked  = (serial_mode_select == MODE_CLOCKED) & ~two_wire_enable;

   // ----------------------------------------
   // pin drive and level readback
   // ----------------------------------------
   // sync clock pin only drives in clocked mode as an output; clock
   // generation itself lives elsewhere, so it drives the idle level
   assign sync_clock_pin_out = 1'b1;
   assign sync_clock_pin_oe  = clocked & sync_clock_dir_out;
   // clock line enable is set beside the busy flag further down
   assign serial_clock_pin_out = 1'b0;
   // data idle level comes from the port register set while disabled
   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe  = two_wire & ~port_data_level;
   assign clock_level = (two_wire | ~clock_pin_dir_out) ? scl : 1'b0;
   assign data_level  = (two_wire | ~data_pin_dir_out) ? sda : 1'b0;

   // ----------------------------------------
   // configuration change tracking
   // ----------------------------------------
   // a half-received byte is dropped when the mode changes, so bits taken
   // in one mode never complete a byte of the other
   logic [1:0] mode_ff, nxt_mode;
   logic       mode_change;

   always_comb begin
      nxt_mode = {two_wire, clocked};
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff <= 2'h0;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   assign mode_change = (mode_ff != nxt_mode);

   // ----------------------------------------
   // receive sequencing
   // ----------------------------------------
   rx_state_e  state_ff, nxt_state;
   logic [3:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic       samp_edge, ninth_rise, ninth_fall, next_fall;
   logic       ld_lsb, ld_msb, ld_split;
   logic       nxt_req14, nxt_req15, nxt_ack, nxt_nack;
   logic       req14_ff, req15_ff, ack_ff, nack_ff;

   // clocked mode samples on the edge picked by the polarity option
   assign samp_edge = two_wire ? scl_rise
                    : (clock_polarity_select ? sck_fall : sck_rise);
   assign ninth_rise = two_wire & scl_rise & (state_ff == ST_ACK);
   assign ninth_fall = two_wire & scl_fall & (state_ff == ST_ACK)
                     & (bit_cnt_ff == ACK_BIT_NUM);
   assign next_fall  = two_wire & scl_fall & (state_ff == ST_AFTER);

   always_comb begin
      nxt_state   = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_shift   = shift_ff;
      ld_lsb      = 1'b0;
      ld_msb      = 1'b0;
      ld_split    = 1'b0;
      nxt_req14   = 1'b0;
      nxt_req15   = 1'b0;
      nxt_ack     = 1'b0;
      nxt_nack    = 1'b0;
      // a start or a stop ends any byte in flight, as does a mode change
      if (!(two_wire | clocked) || mode_change
          || (two_wire && scl && (sda_fall | sda_rise))) begin
         nxt_state   = ST_IDLE;
         nxt_bit_cnt = BIT_CNT_RESET;
      end else begin
         case (state_ff)
            ST_IDLE, ST_DATA: begin
               if (samp_edge) begin
                  // clocked mode receives on the pin shared with the clock
                  nxt_shift   = {shift_ff[6:0], two_wire ? sda : scl};
                  nxt_bit_cnt = bit_cnt_ff + 4'h1;
                  nxt_state   = ST_DATA;
                  if (bit_cnt_ff == 4'(DATA_BITS - 1)) begin
                     if (clocked) begin
                        ld_lsb      = 1'b1;
                        nxt_req14   = 1'b1;
                        nxt_bit_cnt = BIT_CNT_RESET;
                        nxt_state   = ST_IDLE;
                     end else begin
                        nxt_state = ST_ACK;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (ninth_rise) begin
                  nxt_bit_cnt = ACK_BIT_NUM;
                  if (!interrupt_option_select) begin
                     ld_msb    = 1'b1;
                     nxt_ack   = ~sda;
                     nxt_nack  = sda;
                     nxt_req14 = ~sda;
                  end else if (clock_delay_select) begin
                     ld_msb = 1'b1;
                  end
                  if (!clock_delay_select) begin
                     nxt_req15 = 1'b1;
                     nxt_state = ST_IDLE;
                     nxt_bit_cnt = BIT_CNT_RESET;
                  end else begin
                     nxt_state = ST_AFTER;
                  end
               end else if (ninth_fall) begin
                  // another falling edge after the eighth data bit closed, before the ninth rise
               end else if (two_wire && scl_fall
                            && bit_cnt_ff == 4'(DATA_BITS)) begin
                  if (interrupt_option_select) begin
                     ld_split  = 1'b1;
                     nxt_req14 = 1'b1;
                  end
                  nxt_bit_cnt = ACK_BIT_NUM;
               end
            end
            ST_AFTER: begin
               if (next_fall) begin
                  nxt_req15   = 1'b1;
                  nxt_state   = ST_IDLE;
                  nxt_bit_cnt = BIT_CNT_RESET;
               end
            end
            default: nxt_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff   <= ST_IDLE;
         bit_cnt_ff <= BIT_CNT_RESET;
         shift_ff   <= 8'h00;
         req14_ff   <= 1'b0;
         req15_ff   <= 1'b0;
         ack_ff     <= 1'b0;
         nack_ff    <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         shift_ff   <= nxt_shift;
         req14_ff   <= nxt_req14;
         req15_ff   <= nxt_req15;
         ack_ff     <= nxt_ack;
         nack_ff    <= nxt_nack;
      end
   end

   assign req_14   = req14_ff;
   assign req_15   = req15_ff;
   assign ack_irq  = ack_ff;
   assign nack_irq = nack_ff;

   i2c_rx_buffer u_rx_buffer (
      .core_clk       (core_clk),
      .rst_b          (rst_b),
      .load_lsb_first (ld_lsb),
      .load_msb_first (ld_msb),
      .load_split     (ld_split),
      .shift_data     (nxt_shift),
      .receive_buffer (receive_buffer)
   );

   // ----------------------------------------
   // start and stop conditions
   // ----------------------------------------
   logic cond_ff, busy_ff, nxt_cond, nxt_busy;
   logic start_det, stop_det, cond_event;

   assign start_det = two_wire & scl & scl_prev_ff & sda_fall;
   assign stop_det  = two_wire & scl & scl_prev_ff & sda_rise;
   // with automatic output the request marks generation complete
   assign cond_event = condition_output_select ? condition_gen_done
                     : (start_det | stop_det);

   always_comb begin
      nxt_busy = busy_ff;
      if (start_det) begin
         nxt_busy = 1'b1;
      end else if (stop_det) begin
         nxt_busy = 1'b0;
      end
      // set wins over a clear in the same cycle
      nxt_cond = cond_event | (cond_ff & ~condition_clear);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cond_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         cond_ff <= nxt_cond;
         busy_ff <= nxt_busy;
      end
   end

   assign condition_irq = cond_ff;
   assign bus_busy_flag = busy_ff;

   // open-drain idle level: released high, held low with clock delay;
   // only outside a frame, else the far master could never clock it
   assign serial_clock_pin_oe = two_wire & clock_delay_select
                              & ~busy_ff;

endmodule : i2c_cond_detect

/* design/i2c_cond_pkg.sv */
// constants for the two-wire receive and condition detect block
package i2c_cond_pkg;

   // ----------------------------------------
   // mode select encodings
   // ----------------------------------------
   localparam logic [2:0] MODE_DISABLED = 3'h0;
   localparam logic [2:0] MODE_CLOCKED  = 3'h1;
   localparam logic [2:0] MODE_TWO_WIRE = 3'h2;

   // ----------------------------------------
   // frame and buffer layout
   // ----------------------------------------
   localparam int         DATA_BITS     = 8;
   localparam logic [3:0] ACK_BIT_NUM   = 4'h9;
   localparam int         RBUF_W        = 9;
   localparam int         RBUF_SPLIT_HI = 8;
   localparam logic [8:0] RBUF_RESET    = 9'h000;
   localparam logic [3:0] BIT_CNT_RESET = 4'h0;

   // ----------------------------------------
   // receive phase states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DATA  = 2'b01,
      ST_ACK   = 2'b10,
      ST_AFTER = 2'b11
   } rx_state_e;

endpackage : i2c_cond_pkg

/* design/i2c_rx_buffer.sv */
// receive buffer register with three layouts of the shifted byte
module i2c_rx_buffer
   import i2c_cond_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // load controls
   input  wire logic              load_lsb_first,
   input  wire logic              load_msb_first,
   input  wire logic              load_split,
   input  wire logic [7:0]        shift_data,
   // stored value
   output logic      [RBUF_W-1:0] receive_buffer
);

   logic [RBUF_W-1:0] buf_ff;
   logic [RBUF_W-1:0] nxt_buf;
   logic [7:0]        rev;

   // ----------------------------------------
   // bit reversal, one generate loop
   // ----------------------------------------
   for (genvar i = 0; i < DATA_BITS; i++) begin : g_rev
      assign rev[i] = shift_data[DATA_BITS-1-i];
   end

   always_comb begin
      nxt_buf = buf_ff;
      // shift_data holds bit one in [7], bit eight in [0]
      if (load_split) begin
         nxt_buf = {shift_data[0], 1'b0, shift_data[7:1]};
      end else if (load_msb_first) begin
         nxt_buf = {1'b0, shift_data};
      end else if (load_lsb_first) begin
         nxt_buf = {1'b0, rev};
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_ff <= RBUF_RESET;
      end else begin
         buf_ff <= nxt_buf;
      end
   end

   assign receive_buffer = buf_ff;

endmodule : i2c_rx_buffer

/* verification/i2c_cond_detect_assertions.sv */
// concurrent checks on the ports of the condition detect block
module i2c_cond_detect_assertions
   import i2c_cond_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // configuration
   input  wire logic [2:0] serial_mode_select,
   input  wire logic       two_wire_enable,
   input  wire logic       clock_delay_select,
   input  wire logic       clock_pin_dir_out,
   input  wire logic       condition_output_select,
   input  wire logic       condition_clear,
   // pins and status
   input  wire logic       serial_clock_pin_in,
   input  wire logic       serial_clock_pin_oe,
   input  wire logic       sync_clock_pin_oe,
   input  wire logic       clock_level,
   input  wire logic       req_14,
   input  wire logic       ack_irq,
   input  wire logic       nack_irq,
   input  wire logic       condition_irq,
   input  wire logic       bus_busy_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   wire tw = (serial_mode_select == MODE_TWO_WIRE) && two_wire_enable;
   wire ck = (serial_mode_select == MODE_CLOCKED) && !two_wire_enable;

   a_sync_unused: assert property (tw |-> !sync_clock_pin_oe)
      else $error("sync clock pin driven in two-wire mode");
   a_level_read: assert property (
      tw && $past(tw) && $past(tw, 2) |->
      clock_level == $past(serial_clock_pin_in, 2))
      else $error("clock level not readable in two-wire mode");
   a_level_hidden: assert property (
      ck && clock_pin_dir_out |-> !clock_level)
      else $error("clock level readable while pin is output");
   a_scl_idle: assert property (
      tw && !bus_busy_flag |-> serial_clock_pin_oe == clock_delay_select)
      else $error("idle clock line level wrong");
   a_ack_req: assert property (ack_irq |-> req_14)
      else $error("ack without request 14");
   a_nack_quiet: assert property (
      nack_irq |-> !req_14 && !ack_irq)
      else $error("nack with ack or request 14");
   a_cond_sticky: assert property (
      condition_irq && !condition_clear |=> condition_irq)
      else $error("condition request dropped without clear");
   a_busy_irq: assert property (
      !condition_output_select && $changed(bus_busy_flag) |-> condition_irq)
      else $error("busy changed without condition request");
endmodule : i2c_cond_detect_assertions

bind i2c_cond_detect i2c_cond_detect_assertions chk (
   .core_clk, .rst_b, .serial_mode_select, .two_wire_enable,
   .clock_delay_select, .clock_pin_dir_out, .condition_output_select,
   .condition_clear, .serial_clock_pin_in, .serial_clock_pin_oe,
   .sync_clock_pin_oe, .clock_level, .req_14, .ack_irq, .nack_irq,
   .condition_irq, .bus_busy_flag);

/* verification/i2c_bus_model.sv */
// two-wire bus master model driving open-drain clock and data lines
module i2c_bus_model
(
   // clock
   input  wire logic core_clk,
   // line drive, 1 means released to the pull-up
   output logic      scl_drv,
   output logic      sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // half of the 160 ns link period; the link clock stands still between calls
   task automatic half;
      repeat (8) @(negedge core_clk);
   endtask : half
   task automatic start_cond;
      sda_drv = 1'b0;
      half();
      scl_drv = 1'b0;
      half();
   endtask : start_cond
   task automatic stop_cond;
      sda_drv = 1'b0;
      half();
      scl_drv = 1'b1;
      half();
      sda_drv = 1'b1;
      half();
   endtask : stop_cond
   task automatic send(input logic [8:0] bits, input int n);
      scl_drv = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sda_drv = bits[i];
         half();
         scl_drv = 1'b1;
         half();
         scl_drv = 1'b0;
      end
      half();
   endtask : send
endmodule : i2c_bus_model

/* verification/test_i2c_cond_detect.sv */
// self-checking bench for the two-wire receive and condition detect block
module test_i2c_cond_detect
   import i2c_cond_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] mode;
   logic       core_clk, rst_b, twe, iopt, dly, pol, cos, cdir, gdone, cclr;
   logic       scl_oe, sda_oe, sck_oe, clk_lvl, r14, r15, ack, nak, cirq, busy;
   logic [8:0] rbuf, buf14;
   logic       pdl, dat_lvl;
   wire        scl_drv, sda_drv, scl_w, sda_w, ckd;
   int         err_count, n_checks, cyc, n14, n15, na, nn;

   assign scl_w = scl_drv & ~scl_oe;
   assign sda_w = sda_drv & ~sda_oe;
   // in clocked mode the receive data shares the clock line's pin
   assign ckd = (mode == MODE_CLOCKED);

   i2c_bus_model bus (.core_clk(core_clk), .scl_drv(scl_drv), .sda_drv(sda_drv));
   i2c_cond_detect uut (
      .core_clk(core_clk), .rst_b(rst_b), .serial_mode_select(mode),
      .two_wire_enable(twe), .interrupt_option_select(iopt),
      .clock_delay_select(dly), .clock_polarity_select(pol),
      .condition_output_select(cos), .clock_pin_dir_out(cdir),
      .data_pin_dir_out(cdir), .port_data_level(pdl),
      .condition_gen_done(gdone), .condition_clear(cclr),
      .serial_clock_pin_in(ckd ? sda_drv : scl_w),
      .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe),
      .serial_data_pin_in(ckd ? 1'b1 : sda_w), .serial_data_pin_out(),
      .serial_data_pin_oe(sda_oe),
      // the polarity option flips the sync clock, so both options take
      // their samples at the same instants of the model's clock
      .sync_clock_pin_in(ckd ? scl_drv ^ pol : 1'b1),
      .sync_clock_pin_out(), .sync_clock_pin_oe(sck_oe),
      .sync_clock_dir_out(1'b1), .clock_level(clk_lvl),
      .data_level(dat_lvl),
      .receive_buffer(rbuf), .req_14(r14), .req_15(r15), .ack_irq(ack),
      .nack_irq(nak), .condition_irq(cirq), .bus_busy_flag(busy));

   always #5 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      n14 += r14;
      n15 += r15;
      na += ack;
      nn += nak;
      if (r14 === 1'b1) buf14 = rbuf;
   end
   // hang guard: the whole sequence needs about 1100 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         complete_run();
      end
   end

   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic cnts(input int e14, input int e15, input int ea, input int en);
      cmp(9'(n14), 9'(e14));
      cmp(9'(n15), 9'(e15));
      cmp(9'(na), 9'(ea));
      cmp(9'(nn), 9'(en));
   endtask : cnts
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask : wt
   task automatic frame(input logic [8:0] bits, input int n);
      n14 = 0;
      n15 = 0;
      na = 0;
      nn = 0;
      bus.send(bits, n);
      wt(8);
   endtask : frame
   task automatic clr;
      cclr = 1'b1;
      wt(1);
      cclr = 1'b0;
      wt(1);
   endtask : clr
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   initial begin
      {core_clk, rst_b, iopt, dly, pol, cos, gdone, cclr} = '0;
      {mode, twe, cdir, pdl} = {MODE_TWO_WIRE, 3'b111};
      wt(16);
      rst_b = 1'b1;
      wt(4);
      // ----------------------------------------
      // idle levels and pin roles
      // ----------------------------------------
      cmp({rbuf}, RBUF_RESET);
      cmp(9'({scl_oe, sck_oe, clk_lvl, busy, cirq}), 9'h04);
      cmp(9'(dat_lvl), 9'h1);
      dly = 1'b1;
      wt(2);
      cmp(9'(scl_oe), 9'h1);
      dly = 1'b0;
      {mode, twe} = {MODE_CLOCKED, 1'b0};
      wt(4);
      cmp(9'({sck_oe, clk_lvl, dat_lvl}), 9'h4);
      {mode, twe} = {MODE_TWO_WIRE, 1'b1};
      wt(4);
      $display("test idle done");
      // ----------------------------------------
      // frames: ack option, split, split with delay
      // ----------------------------------------
      bus.start_cond();
      cmp(9'({busy, cirq}), 9'h3);
      clr();
      cmp(9'(cirq), 9'h0);
      frame(9'h03a, 9);
      cmp(rbuf, 9'h01d);
      cnts(1, 1, 1, 0);
      frame(9'h03b, 9);
      cnts(0, 1, 0, 1);
      bus.stop_cond();
      cmp(9'({busy, cirq}), 9'h1);
      iopt = 1'b1;
      clr();
      bus.start_cond();
      frame(9'h03a, 9);
      cmp(rbuf, 9'h10e);
      cnts(1, 1, 0, 0);
      dly = 1'b1;
      frame(9'h03a, 9);
      cmp(buf14, 9'h10e);
      cmp(9'(rbuf[7:0]), 9'h01d);
      cnts(1, 1, 0, 0);
      dly = 1'b0;
      bus.stop_cond();
      $display("test frames done");
      // ----------------------------------------
      // generated conditions and clocked mode
      // ----------------------------------------
      {iopt, cos} = 2'b01;
      clr();
      bus.start_cond();
      cmp(9'(cirq), 9'h0);
      gdone = 1'b1;
      wt(1);
      gdone = 1'b0;
      wt(2);
      cmp(9'(cirq), 9'h1);
      bus.stop_cond();
      cos = 1'b0;
      clr();
      {mode, twe, cdir} = {MODE_CLOCKED, 2'b00};
      wt(4);
      cmp(9'({clk_lvl, dat_lvl}), 9'h3);
      frame(9'h01d, 8);
      cmp(rbuf, 9'h0b8);
      cmp(9'(n14), 9'h1);
      pol = 1'b1;
      wt(4);
      frame(9'h03a, 8);
      cmp(rbuf, 9'h05c);
      cmp(9'(n14), 9'h1);
      {mode, twe, pdl} = {MODE_DISABLED, 2'b00};
      wt(4);
      cmp(9'(sda_oe), 9'h0);
      {mode, twe} = {MODE_TWO_WIRE, 1'b1};
      wt(4);
      cmp(9'(sda_oe), 9'h1);
      $display("test modes done");
      complete_run();
   end
endmodule : test_i2c_cond_detect
